// [dv/dram_device_model.sv]
module dram_device_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Command pins
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_i,
  input wire logic [3:0] bank_i,
  input wire logic dll_en_i,
  // Fault tally
  output logic [7:0] faults_o
);
  logic [15:0] rows;
  logic bad;
  // Only row state is kept; timing slack is judged by the checker
  always_comb begin
    case (cmd_i)
      stacked_dram_pkg::OP_ACT: bad = rows[bank_i];
      stacked_dram_pkg::OP_RD, stacked_dram_pkg::OP_WR: bad = !rows[bank_i];
      stacked_dram_pkg::OP_REF: bad = |rows;
      default: bad = 1'b0;
    endcase
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rows <= '0;
      faults_o <= 8'h00;
    end else if (cmd_valid_i) begin
      faults_o <= faults_o + 8'(bad || !dll_en_i);
      if (cmd_i == stacked_dram_pkg::OP_ACT) rows[bank_i] <= 1'b1;
      if (cmd_i == stacked_dram_pkg::OP_PRE) rows[bank_i] <= 1'b0;
    end
  end
endmodule // dram_device_model

// [dv/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPEN_CYC = 40;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic cmd_valid_o, wr_preamble2_o, dll_en_o;
  logic [2:0] cmd_o;
  logic [3:0] bank_o;
  logic [4:0] cl_o, cwl_o;
  logic [7:0] faults;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int ta, t0, t1;

  stacked_dram_timing_ctrl #(.ROW_OPEN_MAX_CYC(OPEN_CYC)) i_stacked_dram_timing_ctrl (.clock_i, .rst_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmd_valid_o, .cmd_o, .bank_o,
    .cl_o, .cwl_o, .wr_preamble2_o, .dll_en_o);
  dram_device_model i_dram_device_model (.clock_i, .rst_i, .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o),
    .bank_i(bank_o), .dll_en_i(dll_en_o), .faults_o(faults));

  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;

  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] cfgw(logic [4:0] cl, logic [4:0] cwl, logic p, logic d);
    return {14'h0, d, p, 3'h0, cwl, 3'h0, cl};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o & m, exp);
  endtask
  task automatic wr_cmd(input logic [2:0] op, input logic [3:0] b);
    wr(stacked_dram_pkg::REG_CMD, {24'h0, b, 1'b0, op});
  endtask
  // Polls at the falling edge, away from the pulse's launch edge
  task automatic wait_cmd(input logic [2:0] op, input logic [3:0] b, output int t);
    int i;
    i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (cmd_valid_o !== 1'b1 && i < 200);
    if (cmd_valid_o !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end else begin
      t = cyc;
      check({cmd_o, bank_o}, {op, b});
    end
  endtask
  task automatic cfg_case(input logic [11:0] tck, input logic [4:0] cl, input logic [4:0] cwl,
                          input logic p, input logic d, input logic [31:0] exp);
    wr(stacked_dram_pkg::REG_TCK, {20'h0, tck});
    wr(stacked_dram_pkg::REG_CFG, cfgw(cl, cwl, p, d));
    rd(stacked_dram_pkg::REG_STATUS, 32'h31, exp);
    check({cwl_o, cl_o, wr_preamble2_o, dll_en_o}, {cwl, cl, p, d});
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(stacked_dram_pkg::REG_CFG, '1, cfgw(stacked_dram_pkg::CL_RST, stacked_dram_pkg::CWL_RST, 1'b0, 1'b1));
    rd(stacked_dram_pkg::REG_TCK, '1, {20'h0, stacked_dram_pkg::TCK_RST});
    rd(stacked_dram_pkg::REG_STATUS, '1, 32'h11);
    rd(8'h10, '1, 32'h0);
    // Period in ps, latencies in clocks
    cfg_case(12'h4e2, 5'h0c, 5'h09, 1'b1, 1'b1, 32'h10);
    cfg_case(12'h4e2, 5'h0c, 5'h0b, 1'b1, 1'b1, 32'h11);
    cfg_case(12'h76d, 5'h0e, 5'h0b, 1'b0, 1'b1, 32'h00);
    cfg_case(12'h76c, 5'h0e, 5'h0b, 1'b0, 1'b1, 32'h11);
    cfg_case(12'h42f, 5'h0e, 5'h0a, 1'b0, 1'b1, 32'h20);
    cfg_case(12'h42f, 5'h0f, 5'h0a, 1'b0, 1'b1, 32'h21);
    cfg_case(12'h4b0, 5'h0d, 5'h0a, 1'b1, 1'b1, 32'h20);
    cfg_case(12'h4e1, 5'h10, 5'h0c, 1'b0, 1'b1, 32'h21);
    cfg_case(12'h4e2, 5'h08, 5'h09, 1'b0, 1'b1, 32'h10);
    cfg_case(12'h4e2, 5'h0c, 5'h0a, 1'b0, 1'b1, 32'h10);
    cfg_case(12'h4e2, 5'h0f, 5'h0b, 1'b0, 1'b1, 32'h10);
    cfg_case(12'h4e2, 5'h0c, 5'h09, 1'b0, 1'b0, 32'h10);
    // An illegal setting holds the command back
    wr_cmd(stacked_dram_pkg::OP_ACT, 4'h3);
    repeat (20) @(posedge clock_i);
    rd(stacked_dram_pkg::REG_STATUS, 32'h6, 32'h2);
    wr_cmd(stacked_dram_pkg::OP_NOP, 4'h3);
    rd(stacked_dram_pkg::REG_STATUS, 32'h6, 32'h6);
    wr(stacked_dram_pkg::REG_CFG, cfgw(5'h0c, 5'h09, 1'b0, 1'b1));
    wait_cmd(stacked_dram_pkg::OP_ACT, 4'h3, t0);
    wr(stacked_dram_pkg::REG_STATUS, 32'h4);
    rd(stacked_dram_pkg::REG_STATUS, 32'h4, 32'h0);
    // A row left open is closed by the controller
    wait_cmd(stacked_dram_pkg::OP_PRE, 4'h3, t1);
    check(t1 - t0, 32'(OPEN_CYC));
    rd(stacked_dram_pkg::REG_STATUS, 32'h8, 32'h8);
    wr(stacked_dram_pkg::REG_STATUS, 32'h8);
    rd(stacked_dram_pkg::REG_STATUS, 32'h8, 32'h0);
    // Commands written back to back, each held only by row timing
    wr_cmd(stacked_dram_pkg::OP_ACT, 4'h2);
    wait_cmd(stacked_dram_pkg::OP_ACT, 4'h2, ta);
    wr_cmd(stacked_dram_pkg::OP_RD, 4'h2);
    wait_cmd(stacked_dram_pkg::OP_RD, 4'h2, t1);
    check(t1 - ta, 32'h4);
    wr_cmd(stacked_dram_pkg::OP_PRE, 4'h2);
    wait_cmd(stacked_dram_pkg::OP_PRE, 4'h2, t1);
    check(t1 - ta, 32'h9);
    wr_cmd(stacked_dram_pkg::OP_ACT, 4'h2);
    wait_cmd(stacked_dram_pkg::OP_ACT, 4'h2, t0);
    check(t0 - ta, 32'hd);
    // Write on the fresh row, so that it too is held by the column delay
    wr_cmd(stacked_dram_pkg::OP_WR, 4'h2);
    wait_cmd(stacked_dram_pkg::OP_WR, 4'h2, t1);
    check(t1 - t0, 32'h4);
    rd(stacked_dram_pkg::REG_STATUS, 32'hffff_0000, 32'h0004_0000);
    wait_cmd(stacked_dram_pkg::OP_PRE, 4'h2, t1);
    wr_cmd(stacked_dram_pkg::OP_REF, 4'h0);
    wait_cmd(stacked_dram_pkg::OP_REF, 4'h0, t0);
    check(t0 - t1, 32'h4);
    check({24'h0, faults}, 32'h0);
    end_sim();
  end
endmodule // tb_top

// [dv/timing_rules_chk.sv]
module timing_rules_chk #(
  parameter int BANKS = 16,
  parameter int BANK_W = 4,
  parameter int ROW_OPEN_MAX_CYC = 17550
) (
  // Clock, reset, register writes
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Device pins
  input wire logic cmd_valid_o,
  input wire logic [2:0] cmd_o,
  input wire logic [BANK_W-1:0] bank_o,
  input wire logic [4:0] cl_o,
  input wire logic [4:0] cwl_o,
  input wire logic wr_preamble2_o,
  input wire logic dll_en_o
);
  int act_age [BANKS];
  int pre_age [BANKS];
  logic [BANKS-1:0] open;
  logic [11:0] tck;
  logic stale;
  wire logic is_act = cmd_valid_o && cmd_o == stacked_dram_pkg::OP_ACT;
  wire logic is_pre = cmd_valid_o && cmd_o == stacked_dram_pkg::OP_PRE;
  wire logic is_col = cmd_valid_o && cmd_o inside {stacked_dram_pkg::OP_RD, stacked_dram_pkg::OP_WR};
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) tck <= stacked_dram_pkg::TCK_RST;
    else if (reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_TCK) tck <= reg_wdata_i[11:0];
  end
  // Ages saturate so banks idle since reset count as long idle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      open <= '0;
      for (int b = 0; b < BANKS; b++) begin
        act_age[b] <= 100000;
        pre_age[b] <= 100000;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        act_age[b] <= act_age[b] + int'(act_age[b] < 100000);
        pre_age[b] <= pre_age[b] + int'(pre_age[b] < 100000);
      end
      if (is_act) begin
        act_age[bank_o] <= 1;
        open[bank_o] <= 1'b1;
      end
      if (is_pre) begin
        pre_age[bank_o] <= 1;
        open[bank_o] <= 1'b0;
      end
    end
  end
  always_comb begin
    stale = 1'b0;
    for (int b = 0; b < BANKS; b++) begin
      if (open[b] && act_age[b] > ROW_OPEN_MAX_CYC + 2) stale = 1'b1;
    end
  end
  cwl_le_cl_a: assert property (cmd_valid_o |-> cwl_o <= cl_o)
    else $error("write latency above read latency");
  pre2_cwl_a: assert property (cmd_valid_o && wr_preamble2_o |-> cwl_o >= (tck < 12'h4e2 ? 11 : 10))
    else $error("write latency too low for long preamble");
  dll_on_a: assert property (cmd_valid_o |-> dll_en_o)
    else $error("command with delay loop off");
  act_gap_a: assert property (is_act |-> !open[bank_o] && act_age[bank_o] >= 13 && pre_age[bank_o] >= 4)
    else $error("activate too soon");
  pre_ras_a: assert property (is_pre |-> open[bank_o] && act_age[bank_o] >= 9)
    else $error("precharge too soon");
  col_delay_a: assert property (is_col |-> open[bank_o] && act_age[bank_o] >= 4)
    else $error("column command too soon");
  taa_window_a: assert property (cmd_valid_o |-> int'(cl_o) * int'(tck) inside {[15000:27000]})
    else $error("read latency outside window");
  tck_range_a: assert property (cmd_valid_o |-> tck inside {[1071:1900]})
    else $error("clock period outside ranges");
  ref_idle_a: assert property (cmd_valid_o && cmd_o == stacked_dram_pkg::OP_REF |-> open == '0)
    else $error("refresh with open row");
  row_open_a: assert property (!stale)
    else $error("row held open too long");
  cover property (is_col);
  cover property (cmd_valid_o && cmd_o == stacked_dram_pkg::OP_REF);
  cover property (is_pre && act_age[bank_o] >= ROW_OPEN_MAX_CYC);
endmodule // timing_rules_chk

bind stacked_dram_timing_ctrl timing_rules_chk #(.BANKS(BANKS), .BANK_W(BANK_W), .ROW_OPEN_MAX_CYC(ROW_OPEN_MAX_CYC))
  i_timing_rules_chk (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .cmd_valid_o, .cmd_o, .bank_o,
  .cl_o, .cwl_o, .wr_preamble2_o, .dll_en_o);

// [inc/bank_if.sv]
interface bank_if #(parameter int BANKS = 16);
  logic [BANKS-1:0] act, pre, open, act_ok, col_ok, pre_ok, overdue;
  logic [7:0] trcd, trp, tras, trc;
  logic [15:0] tras_max;
  modport ctrl (output act, pre, trcd, trp, tras, trc, tras_max,
                input open, act_ok, col_ok, pre_ok, overdue);
  modport bank (input act, pre, trcd, trp, tras, trc, tras_max,
                output open, act_ok, col_ok, pre_ok, overdue);
endinterface

// [inc/stacked_dram_pkg.sv]
package stacked_dram_pkg;
  localparam int CLK_PS = 4000;

  // Register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_TCK = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Field positions
  localparam int CFG_CL_LSB = 0;
  localparam int CFG_CWL_LSB = 8;
  localparam int CFG_PRE2_BIT = 16;
  localparam int CFG_DLL_BIT = 17;
  localparam int TCK_LSB = 0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int ST_CFG_OK_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_OVERDUE_BIT = 3;
  localparam int ST_RANGE_LSB = 4;
  localparam int ST_OPEN_LSB = 16;

  // Values after reset
  localparam logic [4:0] CL_RST = 5'h0c;
  localparam logic [4:0] CWL_RST = 5'h09;
  localparam logic [11:0] TCK_RST = 12'h4e2;

  // Clock-period ranges in ps
  localparam int TCK_1600_MIN_PS = 1250;
  localparam int TCK_1600_MAX_PS = 1900;
  localparam int TCK_1866_MIN_PS = 1071;

  // Latency settings in clocks
  localparam int CL_MIN = 12;
  localparam int CL_MAX_1600 = 14;
  localparam int CL_MAX_1866 = 16;
  localparam int CL_NATIVE_1866 = 14;
  localparam int CWL_A_1600 = 9;
  localparam int CWL_B_1600 = 11;
  localparam int CWL_MIN = 9;
  localparam int CWL_MAX_1866 = 12;
  localparam int CWL_LOW_1600 = 9;
  localparam int CWL_LOW_1866 = 10;
  localparam int PRE2_CWL_EXTRA = 1;

  // Read latency window in ps
  localparam int TAA_MIN_PS = 15000;
  localparam int TAA_MAX_PS = 27000;

  // Row timing in ps and derived cycles, rounded up
  localparam int TRCD_1600_PS = 13750;
  localparam int TRCD_1866_PS = 13920;
  localparam int TRCD_1866_RELAX_PS = 13750;
  localparam int TRP_1600_PS = 12500;
  localparam int TRP_1866_PS = 12850;
  localparam int TRP_1866_RELAX_PS = 12500;
  localparam int TRAS_1600_PS = 35000;
  localparam int TRAS_1866_PS = 34000;
  localparam int TRCD_1600_CYC = (TRCD_1600_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRCD_1866_CYC = (TRCD_1866_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRCD_1866_RELAX_CYC = (TRCD_1866_RELAX_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRP_1600_CYC = (TRP_1600_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRP_1866_CYC = (TRP_1866_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRP_1866_RELAX_CYC = (TRP_1866_RELAX_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRAS_1600_CYC = (TRAS_1600_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRAS_1866_CYC = (TRAS_1866_PS + CLK_PS - 1) / CLK_PS;

  // Longest row open time, rounded down
  localparam int REFI_NS = 7800;
  localparam int ROW_OPEN_MAX_NS = 9 * REFI_NS;
  localparam int ROW_OPEN_MAX_CYC = (ROW_OPEN_MAX_NS * 1000) / CLK_PS;

  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF} op_e;
  typedef enum logic [1:0] {RANGE_NONE, RANGE_1600, RANGE_1866} range_e;
endpackage

// [verilog/bank_timer.sv]
module bank_timer #(
  parameter int IDX = 0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Bank timing bus
  bank_if.bank bus
);
  logic [15:0] since_act;
  logic [15:0] since_pre;
  logic is_open;

  // Counters saturate so an idle bank stays ready forever
  // Counting from one makes a limit of n cycles space the pulses by exactly n
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      since_act <= 16'hffff;
    end else if (bus.act[IDX]) begin
      since_act <= 16'h0001;
    end else if (since_act != 16'hffff) begin
      since_act <= since_act + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      since_pre <= 16'hffff;
    end else if (bus.pre[IDX]) begin
      since_pre <= 16'h0001;
    end else if (since_pre != 16'hffff) begin
      since_pre <= since_pre + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      is_open <= 1'b0;
    end else if (bus.act[IDX]) begin
      is_open <= 1'b1;
    end else if (bus.pre[IDX]) begin
      is_open <= 1'b0;
    end
  end

  assign bus.open[IDX] = is_open;
  // Row cycle and precharge period checked each on its own
  assign bus.act_ok[IDX] = !is_open && since_pre >= 16'(bus.trp) && since_act >= 16'(bus.trc);
  assign bus.col_ok[IDX] = is_open && since_act >= 16'(bus.trcd);
  assign bus.pre_ok[IDX] = is_open && since_act >= 16'(bus.tras);
  assign bus.overdue[IDX] = is_open && since_act >= bus.tras_max;
endmodule // bank_timer

// [verilog/stacked_dram_timing_ctrl.sv]
module stacked_dram_timing_ctrl #(
  parameter int BANKS = 16,
  parameter int BANK_W = 4,
  parameter int ROW_OPEN_MAX_CYC = stacked_dram_pkg::ROW_OPEN_MAX_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Device command bus
  output logic cmd_valid_o,
  output logic [2:0] cmd_o,
  output logic [BANK_W-1:0] bank_o,
  // Mode settings for the device
  output logic [4:0] cl_o,
  output logic [4:0] cwl_o,
  output logic wr_preamble2_o,
  output logic dll_en_o
);
  bank_if #(.BANKS(BANKS)) bus ();

  logic [4:0] cl;
  logic [4:0] cwl;
  logic preamble2;
  logic dll_en;
  logic [11:0] tck_ps;
  logic pending;
  stacked_dram_pkg::op_e pend_op;
  logic [BANK_W-1:0] pend_bank;
  logic refused;
  logic overdue_seen;
  stacked_dram_pkg::range_e rng;
  logic cl_ok;
  logic cwl_ok;
  logic pre2_ok;
  logic [16:0] taa_ps;
  logic cfg_ok;
  logic native;
  logic [7:0] trcd_c;
  logic [7:0] trp_c;
  logic [7:0] tras_c;
  logic allowed;
  logic issue;
  logic force_pre;
  logic [BANK_W-1:0] force_bank;
  logic cmd_wr;
  logic op_legal;
  logic take_cmd;
  logic [2:0] wr_op;

  assign cmd_wr = reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_CMD;
  assign wr_op = reg_wdata_i[stacked_dram_pkg::CMD_OP_LSB +: 3];
  assign op_legal = wr_op >= 3'(stacked_dram_pkg::OP_ACT) && wr_op <= 3'(stacked_dram_pkg::OP_REF);
  assign take_cmd = cmd_wr && !pending && op_legal;

  // Configuration registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cl <= stacked_dram_pkg::CL_RST;
      cwl <= stacked_dram_pkg::CWL_RST;
      preamble2 <= 1'b0;
      dll_en <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_CFG) begin
      cl <= reg_wdata_i[stacked_dram_pkg::CFG_CL_LSB +: 5];
      cwl <= reg_wdata_i[stacked_dram_pkg::CFG_CWL_LSB +: 5];
      preamble2 <= reg_wdata_i[stacked_dram_pkg::CFG_PRE2_BIT];
      dll_en <= reg_wdata_i[stacked_dram_pkg::CFG_DLL_BIT];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tck_ps <= stacked_dram_pkg::TCK_RST;
    end else if (reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_TCK) begin
      tck_ps <= reg_wdata_i[stacked_dram_pkg::TCK_LSB +: 12];
    end
  end

  // Clock-period range of the programmed device clock
  always_comb begin
    if (tck_ps >= 12'(stacked_dram_pkg::TCK_1600_MIN_PS) &&
        tck_ps <= 12'(stacked_dram_pkg::TCK_1600_MAX_PS)) begin
      rng = stacked_dram_pkg::RANGE_1600;
    end else if (tck_ps >= 12'(stacked_dram_pkg::TCK_1866_MIN_PS) &&
                 tck_ps < 12'(stacked_dram_pkg::TCK_1600_MIN_PS)) begin
      rng = stacked_dram_pkg::RANGE_1866;
    end else begin
      rng = stacked_dram_pkg::RANGE_NONE;
    end
  end

  // Latency settings legal only inside their own range
  always_comb begin
    cl_ok = 1'b0;
    cwl_ok = 1'b0;
    pre2_ok = 1'b0;
    unique case (rng)
      stacked_dram_pkg::RANGE_1600: begin
        cl_ok = cl >= 5'(stacked_dram_pkg::CL_MIN) && cl <= 5'(stacked_dram_pkg::CL_MAX_1600);
        cwl_ok = cwl == 5'(stacked_dram_pkg::CWL_A_1600) || cwl == 5'(stacked_dram_pkg::CWL_B_1600);
        pre2_ok = cwl >= 5'(stacked_dram_pkg::CWL_LOW_1600 + stacked_dram_pkg::PRE2_CWL_EXTRA);
      end
      stacked_dram_pkg::RANGE_1866: begin
        cl_ok = cl >= 5'(stacked_dram_pkg::CL_MIN) && cl <= 5'(stacked_dram_pkg::CL_MAX_1866);
        cwl_ok = cwl >= 5'(stacked_dram_pkg::CWL_MIN) && cwl <= 5'(stacked_dram_pkg::CWL_MAX_1866);
        pre2_ok = cwl >= 5'(stacked_dram_pkg::CWL_LOW_1866 + stacked_dram_pkg::PRE2_CWL_EXTRA);
      end
      default: begin
        cl_ok = 1'b0;
        cwl_ok = 1'b0;
        pre2_ok = 1'b0;
      end
    endcase
  end

  assign taa_ps = 17'(cl) * 17'(tck_ps);

  // Pending commands stall rather than run on limits the device does not promise
  assign cfg_ok = dll_en
               && rng != stacked_dram_pkg::RANGE_NONE
               && cl_ok
               && cwl_ok
               && cwl <= cl
               && (!preamble2 || pre2_ok)
               && taa_ps >= 17'(stacked_dram_pkg::TAA_MIN_PS)
               && taa_ps <= 17'(stacked_dram_pkg::TAA_MAX_PS);

  // Relaxed delays are taken only off the native latency
  assign native = rng == stacked_dram_pkg::RANGE_1866 && cl == 5'(stacked_dram_pkg::CL_NATIVE_1866);

  always_comb begin
    if (rng == stacked_dram_pkg::RANGE_1866) begin
      trcd_c = native ? 8'(stacked_dram_pkg::TRCD_1866_CYC)
                      : 8'(stacked_dram_pkg::TRCD_1866_RELAX_CYC);
      trp_c = native ? 8'(stacked_dram_pkg::TRP_1866_CYC)
                     : 8'(stacked_dram_pkg::TRP_1866_RELAX_CYC);
      tras_c = 8'(stacked_dram_pkg::TRAS_1866_CYC);
    end else begin
      trcd_c = 8'(stacked_dram_pkg::TRCD_1600_CYC);
      trp_c = 8'(stacked_dram_pkg::TRP_1600_CYC);
      tras_c = 8'(stacked_dram_pkg::TRAS_1600_CYC);
    end
  end

  assign bus.trcd = trcd_c;
  assign bus.trp = trp_c;
  assign bus.tras = tras_c;
  // Sum of separately rounded counts meets tRC, tRAS and tRP together
  assign bus.trc = 8'(trp_c + tras_c);
  assign bus.tras_max = 16'(ROW_OPEN_MAX_CYC);

  // Lowest overdue bank is closed first
  always_comb begin
    force_pre = 1'b0;
    force_bank = '0;
    for (int i = BANKS - 1; i >= 0; i--) begin
      if (bus.overdue[i]) begin
        force_pre = 1'b1;
        force_bank = BANK_W'(i);
      end
    end
  end

  always_comb begin
    unique case (pend_op)
      stacked_dram_pkg::OP_ACT: allowed = bus.act_ok[pend_bank];
      stacked_dram_pkg::OP_RD,
      stacked_dram_pkg::OP_WR: allowed = bus.col_ok[pend_bank];
      stacked_dram_pkg::OP_PRE: allowed = bus.pre_ok[pend_bank];
      stacked_dram_pkg::OP_REF: allowed = &bus.act_ok;
      default: allowed = 1'b0;
    endcase
  end

  // Forced precharge takes the slot; the pending command waits
  assign issue = pending && cfg_ok && allowed && !force_pre;

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      assign bus.act[g] = issue && pend_op == stacked_dram_pkg::OP_ACT && pend_bank == BANK_W'(g);
      assign bus.pre[g] = (issue && pend_op == stacked_dram_pkg::OP_PRE && pend_bank == BANK_W'(g))
                       || (force_pre && force_bank == BANK_W'(g));
      bank_timer #(.IDX(g)) u_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .bus(bus)
      );
    end
  endgenerate

  // Pending command slot
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= 1'b0;
      pend_op <= stacked_dram_pkg::OP_NOP;
      pend_bank <= '0;
    end else if (take_cmd) begin
      pending <= 1'b1;
      pend_op <= stacked_dram_pkg::op_e'(wr_op);
      pend_bank <= reg_wdata_i[stacked_dram_pkg::CMD_BANK_LSB +: BANK_W];
    end else if (issue) begin
      pending <= 1'b0;
    end
  end

  // Sticky flags; a new event wins over the clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      refused <= 1'b0;
    end else if (cmd_wr && (pending || !op_legal)) begin
      refused <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_STATUS &&
                 reg_wdata_i[stacked_dram_pkg::ST_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      overdue_seen <= 1'b0;
    end else if (force_pre) begin
      overdue_seen <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == stacked_dram_pkg::REG_STATUS &&
                 reg_wdata_i[stacked_dram_pkg::ST_OVERDUE_BIT]) begin
      overdue_seen <= 1'b0;
    end
  end

  // Device command outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= 3'h0;
      bank_o <= '0;
    end else begin
      cmd_valid_o <= issue || force_pre;
      cmd_o <= force_pre ? 3'(stacked_dram_pkg::OP_PRE) : 3'(pend_op);
      bank_o <= force_pre ? force_bank : pend_bank;
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      unique case (reg_addr_i)
        stacked_dram_pkg::REG_CFG: begin
          reg_rdata_o[stacked_dram_pkg::CFG_CL_LSB +: 5] <= cl;
          reg_rdata_o[stacked_dram_pkg::CFG_CWL_LSB +: 5] <= cwl;
          reg_rdata_o[stacked_dram_pkg::CFG_PRE2_BIT] <= preamble2;
          reg_rdata_o[stacked_dram_pkg::CFG_DLL_BIT] <= dll_en;
        end
        stacked_dram_pkg::REG_TCK: reg_rdata_o[stacked_dram_pkg::TCK_LSB +: 12] <= tck_ps;
        stacked_dram_pkg::REG_CMD: begin
          reg_rdata_o[stacked_dram_pkg::CMD_OP_LSB +: 3] <= 3'(pend_op);
          reg_rdata_o[stacked_dram_pkg::CMD_BANK_LSB +: BANK_W] <= pend_bank;
        end
        stacked_dram_pkg::REG_STATUS: begin
          reg_rdata_o[stacked_dram_pkg::ST_CFG_OK_BIT] <= cfg_ok;
          reg_rdata_o[stacked_dram_pkg::ST_PEND_BIT] <= pending;
          reg_rdata_o[stacked_dram_pkg::ST_REFUSED_BIT] <= refused;
          reg_rdata_o[stacked_dram_pkg::ST_OVERDUE_BIT] <= overdue_seen;
          reg_rdata_o[stacked_dram_pkg::ST_RANGE_LSB +: 2] <= 2'(rng);
          reg_rdata_o[stacked_dram_pkg::ST_OPEN_LSB +: BANKS] <= bus.open;
        end
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign cl_o = cl;
  assign cwl_o = cwl;
  assign wr_preamble2_o = preamble2;
  assign dll_en_o = dll_en;
endmodule // stacked_dram_timing_ctrl
